/* pkg/walker_defs.vh */
// constants for the long-mode page-translation walker: register map, field positions, entry layout
// assumes inclusion by bare name from the walker design file; definitions only
`ifndef WALKER_DEFS_VH
`define WALKER_DEFS_VH

// avalon byte offsets, one aligned 32-bit word each
`define OFS_ROOT_LO 5'h00
`define OFS_ROOT_HI 5'h04
`define OFS_CONTROL 5'h08
`define OFS_STATUS 5'h0C
`define OFS_RESULT_LO 5'h10
`define OFS_RESULT_HI 5'h14
`define OFS_FAULT_VA_LO 5'h18
`define OFS_FAULT_VA_HI 5'h1C

// control register bits
`define CTL_PAE_BIT 0
`define CTL_PSE_BIT 1
`define CTL_LONG_BIT 2
`define CTL_WIDTH 3

// status register bits
`define ST_LONG_ACTIVE_BIT 0
`define ST_BUSY_BIT 1
`define ST_MODE_GP_BIT 2
`define ST_ADDR_GP_BIT 3
`define ST_ADDR_SS_BIT 4
`define ST_SIZE_LO_BIT 5
`define ST_SIZE_HI_BIT 6

// page-size codes reported with each translation
`define SIZE_4K 2'h0
`define SIZE_2M 2'h1
`define SIZE_1G 2'h2

// root pointer fields
`define ROOT_PWT_BIT 3
`define ROOT_PCD_BIT 4
`define ROOT_BASE_LSB 12
`define ROOT_RESET 64'h0000000000000000

// table entry and virtual-address layout
`define ENTRY_BYTES_LOG2 3
`define ENTRY_PS_BIT 7
`define IDX_WIDTH 9
`define PAGE_SHIFT 12
`define L1_IDX_LSB 12
`define L2_IDX_LSB 21
`define L3_IDX_LSB 30
`define L4_IDX_LSB 39
`define VA_WIDTH 64
`define ENTRY_WIDTH 64

`endif

/* rtl/long_mode_page_walker.v */
// long-mode four-level page-translation walker with an avalon-mm register slave
// assumes core, table memory and bus master all run on i_ref_clk; memory holds each read until it answers
`timescale 1ns/1ps
`default_nettype none
`include "walker_defs.vh"

// What this block does
// - long mode without extension enable faults while long mode is off
// - virtual 64-bit maps to 52-bit physical
// - every fetched entry is 64 bits wide
// - walk starts at level-4 map table
// - directory page-size bit picks 4K or 2M
// - legacy large-page enable ignored in long mode
// - optional pointer page-size bit gives 1G page
// - canonical when top bits all equal
// - non-canonical byte gives protection or stack fault
// - 64-bit root pointer, base in 51:12
// - level-4 base has bits 11:0 zero
// - root bit 3 selects writethrough for top table
// - root bit 4 marks top table uncacheable
// - 512-entry tables indexed by 47:39, 38:30, 29:21
// - 4K page: 20:12 index, 11:0 offset
// - bits 63:48 copy bit 47
// - 2M page: stop at directory, offset 20:0
// - directory bit 7 clear continues to page table
// - sign and level-4 widths follow VA_BITS
// - directory bit 7 set ends walk, 2M
module long_mode_page_walker
#(
   parameter VA_BITS = 48,
   parameter PA_BITS = 52,
   parameter GBYTE_PAGES = 0
)
(
   input wire i_ref_clk,
   input wire i_rst,
   // avalon-mm register slave
   input wire [4:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   // core translation requests
   input wire i_req_valid,
   input wire [63:0] i_req_vaddr,
   input wire [2:0] i_req_last_byte,
   input wire i_req_stack,
   output wire o_req_ready,
   output reg o_resp_valid,
   output reg [63:0] o_resp_paddr,
   output reg [1:0] o_resp_page_size,
   output reg o_resp_gp_fault,
   output reg o_resp_ss_fault,
   // table memory reads
   output reg o_mem_read,
   output reg [63:0] o_mem_addr,
   output reg o_mem_writethrough,
   output reg o_mem_uncached,
   input wire i_mem_valid,
   input wire [63:0] i_mem_rdata
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_L4 = 3'h1;
   localparam [2:0] ST_L3 = 3'h2;
   localparam [2:0] ST_L2 = 3'h3;
   localparam [2:0] ST_L1 = 3'h4;

   localparam [63:0] PA_MASK = (64'h1 << PA_BITS) - 64'h1;
   localparam [63:0] BASE_MASK = PA_MASK & ~((64'h1 << `PAGE_SHIFT) - 64'h1);
   localparam [63:0] L4_IDX_MASK = (64'h1 << (VA_BITS - `L4_IDX_LSB)) - 64'h1;

   reg [63:0] translation_root_pointer;
   reg [`CTL_WIDTH-1:0] control;
   reg long_active;
   reg mode_gp;
   reg addr_gp;
   reg addr_ss;
   reg [1:0] last_size;
   reg [63:0] fault_va;
   reg [2:0] state;
   reg [63:0] vaddr;
   reg [63:0] root_snap;
   reg bus_ack;

   wire phys_addr_extension_enable;
   wire legacy_large_page_enable;
   wire bus_req;
   wire wr_ok;
   wire [63:0] req_end;
   wire start_canon;
   wire end_canon;
   wire [63:0] entry_base;
   wire directory_page_size_bit;
   wire pointer_page_size_bit;
   wire [31:0] status_word;
   wire mode_gp_event;
   wire addr_fault_event;

   assign phys_addr_extension_enable = control[`CTL_PAE_BIT];
   // kept only so software can read back what it wrote; page size never looks at it
   assign legacy_large_page_enable = control[`CTL_PSE_BIT];

   // canonical test: bits VA_BITS-1..63 all equal, i.e. 63:48 copy 47 at the default width
   function canonical;
      input [63:0] va;
      reg [63:0] upper;
      begin
         upper = va >> (VA_BITS - 1);
         canonical = (upper == 64'h0) || (upper == ({64{1'b1}} >> (VA_BITS - 1)));
      end
   endfunction

   // entry address: table base plus nine-bit index times eight bytes
   function [63:0] entry_addr;
      input [63:0] base;
      input [8:0] idx;
      begin
         entry_addr = (base & BASE_MASK) | ({55'h0, idx} << `ENTRY_BYTES_LOG2);
      end
   endfunction

   // byte-lane merge for avalon writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0] be;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
         begin
            if (be[k])
            begin
               merge[k*8 +: 8] = din[k*8 +: 8];
            end
         end
      end
   endfunction

   assign req_end = i_req_vaddr + {61'h0, i_req_last_byte};
   assign start_canon = canonical(i_req_vaddr);
   assign end_canon = canonical(req_end);
   assign entry_base = i_mem_rdata & BASE_MASK;
   assign directory_page_size_bit = i_mem_rdata[`ENTRY_PS_BIT];
   assign pointer_page_size_bit = i_mem_rdata[`ENTRY_PS_BIT];

   // ---------------- avalon slave: one wait cycle on every access ----------------
   assign bus_req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = bus_req & ~bus_ack;
   assign wr_ok = i_avs_write & bus_ack;

   always @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         bus_ack <= 1'b0;
      end
      else
      begin
         bus_ack <= bus_req & ~bus_ack;
      end
   end

   assign status_word = {25'h0, last_size, addr_ss, addr_gp, mode_gp, (state != ST_IDLE), long_active};

   always @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_avs_readdata <= 32'h0;
      end
      else if (i_avs_read & ~bus_ack)
      begin
         case (i_avs_address)
            `OFS_ROOT_LO: o_avs_readdata <= translation_root_pointer[31:0];
            `OFS_ROOT_HI: o_avs_readdata <= translation_root_pointer[63:32];
            `OFS_CONTROL: o_avs_readdata <= {29'h0, control};
            `OFS_STATUS: o_avs_readdata <= status_word;
            `OFS_RESULT_LO: o_avs_readdata <= o_resp_paddr[31:0];
            `OFS_RESULT_HI: o_avs_readdata <= o_resp_paddr[63:32];
            `OFS_FAULT_VA_LO: o_avs_readdata <= fault_va[31:0];
            `OFS_FAULT_VA_HI: o_avs_readdata <= fault_va[63:32];
            default: o_avs_readdata <= 32'h0;
         endcase
      end
   end

   // root pointer: stored whole; reserved bits are software's to keep zero
   always @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         translation_root_pointer <= `ROOT_RESET;
      end
      else if (wr_ok && i_avs_address == `OFS_ROOT_LO)
      begin
         translation_root_pointer[31:0] <= merge(translation_root_pointer[31:0], i_avs_writedata,
                                                 i_avs_byteenable);
      end
      else if (wr_ok && i_avs_address == `OFS_ROOT_HI)
      begin
         translation_root_pointer[63:32] <= merge(translation_root_pointer[63:32], i_avs_writedata,
                                                  i_avs_byteenable);
      end
   end

   // control write: a long-mode request without extension enable is refused, and faulted only while long mode is off
   wire [31:0] ctl_new;
   assign ctl_new = merge({29'h0, control}, i_avs_writedata, i_avs_byteenable);
   assign mode_gp_event = wr_ok && (i_avs_address == `OFS_CONTROL) && ctl_new[`CTL_LONG_BIT] &&
                          !long_active && !ctl_new[`CTL_PAE_BIT];

   always @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         control <= {`CTL_WIDTH{1'b0}};
         long_active <= 1'b0;
      end
      else if (wr_ok && i_avs_address == `OFS_CONTROL)
      begin
         control <= ctl_new[`CTL_WIDTH-1:0];
         // extension enable may not drop while long mode stays on
         long_active <= ctl_new[`CTL_LONG_BIT] & ctl_new[`CTL_PAE_BIT];
      end
   end

   assign addr_fault_event = i_req_valid && o_req_ready && long_active && !(start_canon && end_canon);
   wire st_clr;
   assign st_clr = wr_ok && (i_avs_address == `OFS_STATUS) && i_avs_byteenable[0];

   // sticky fault flags, write one to clear in status; a new event in the same cycle wins
   always @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         mode_gp <= 1'b0;
         addr_gp <= 1'b0;
         addr_ss <= 1'b0;
         fault_va <= 64'h0;
      end
      else
      begin
         mode_gp <= mode_gp_event | (mode_gp & ~(st_clr & i_avs_writedata[`ST_MODE_GP_BIT]));
         addr_gp <= (addr_fault_event & ~i_req_stack) | (addr_gp & ~(st_clr & i_avs_writedata[`ST_ADDR_GP_BIT]));
         addr_ss <= (addr_fault_event & i_req_stack) | (addr_ss & ~(st_clr & i_avs_writedata[`ST_ADDR_SS_BIT]));
         if (addr_fault_event)
         begin
            fault_va <= start_canon ? req_end : i_req_vaddr;
         end
      end
   end

   // ---------------- walk state machine ----------------
   // one request at a time; the core must wait for ready, which also stalls it during a walk
   assign o_req_ready = (state == ST_IDLE);

   always @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= ST_IDLE;
         vaddr <= 64'h0;
         root_snap <= 64'h0;
         last_size <= `SIZE_4K;
         o_resp_valid <= 1'b0;
         o_resp_paddr <= 64'h0;
         o_resp_page_size <= `SIZE_4K;
         o_resp_gp_fault <= 1'b0;
         o_resp_ss_fault <= 1'b0;
         o_mem_read <= 1'b0;
         o_mem_addr <= 64'h0;
         o_mem_writethrough <= 1'b0;
         o_mem_uncached <= 1'b0;
      end
      else
      begin
         o_resp_valid <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (i_req_valid)
               begin
                  vaddr <= i_req_vaddr;
                  root_snap <= translation_root_pointer;
                  if (!long_active || !(start_canon && end_canon))
                  begin
                     // outside long mode or non-canonical: answer with a fault, no memory read
                     o_resp_valid <= 1'b1;
                     o_resp_paddr <= 64'h0;
                     o_resp_page_size <= `SIZE_4K;
                     o_resp_gp_fault <= !long_active || !i_req_stack;
                     o_resp_ss_fault <= long_active && i_req_stack;
                  end
                  else
                  begin
                     state <= ST_L4;
                     o_mem_read <= 1'b1;
                     // base bits 11:0 forced to zero, index 47:39 trimmed to VA_BITS
                     o_mem_addr <= entry_addr(translation_root_pointer,
                                              i_req_vaddr[`L4_IDX_LSB +: `IDX_WIDTH] &
                                              L4_IDX_MASK[`IDX_WIDTH-1:0]);
                     o_mem_writethrough <= translation_root_pointer[`ROOT_PWT_BIT];
                     o_mem_uncached <= translation_root_pointer[`ROOT_PCD_BIT];
                  end
               end
            end
            ST_L4:
            begin
               if (i_mem_valid)
               begin
                  state <= ST_L3;
                  o_mem_addr <= entry_addr(entry_base, vaddr[`L3_IDX_LSB +: `IDX_WIDTH]);
                  // caching attributes from the root apply to the top table only
                  o_mem_writethrough <= 1'b0;
                  o_mem_uncached <= 1'b0;
               end
            end
            ST_L3:
            begin
               if (i_mem_valid)
               begin
                  if (GBYTE_PAGES != 0 && pointer_page_size_bit)
                  begin
                     state <= ST_IDLE;
                     o_mem_read <= 1'b0;
                     o_resp_valid <= 1'b1;
                     o_resp_paddr <= (entry_base & ~((64'h1 << `L3_IDX_LSB) - 64'h1)) |
                                     (vaddr & ((64'h1 << `L3_IDX_LSB) - 64'h1));
                     o_resp_page_size <= `SIZE_1G;
                     last_size <= `SIZE_1G;
                     o_resp_gp_fault <= 1'b0;
                     o_resp_ss_fault <= 1'b0;
                  end
                  else
                  begin
                     state <= ST_L2;
                     o_mem_addr <= entry_addr(entry_base, vaddr[`L2_IDX_LSB +: `IDX_WIDTH]);
                  end
               end
            end
            ST_L2:
            begin
               if (i_mem_valid)
               begin
                  // page size comes from the directory entry alone, never the legacy enable
                  if (directory_page_size_bit)
                  begin
                     state <= ST_IDLE;
                     o_mem_read <= 1'b0;
                     o_resp_valid <= 1'b1;
                     o_resp_paddr <= (entry_base & ~((64'h1 << `L2_IDX_LSB) - 64'h1)) |
                                     (vaddr & ((64'h1 << `L2_IDX_LSB) - 64'h1));
                     o_resp_page_size <= `SIZE_2M;
                     last_size <= `SIZE_2M;
                     o_resp_gp_fault <= 1'b0;
                     o_resp_ss_fault <= 1'b0;
                  end
                  else
                  begin
                     state <= ST_L1;
                     o_mem_addr <= entry_addr(entry_base, vaddr[`L1_IDX_LSB +: `IDX_WIDTH]);
                  end
               end
            end
            ST_L1:
            begin
               if (i_mem_valid)
               begin
                  state <= ST_IDLE;
                  o_mem_read <= 1'b0;
                  o_resp_valid <= 1'b1;
                  o_resp_paddr <= entry_base | (vaddr & ((64'h1 << `PAGE_SHIFT) - 64'h1));
                  o_resp_page_size <= `SIZE_4K;
                  last_size <= `SIZE_4K;
                  o_resp_gp_fault <= 1'b0;
                  o_resp_ss_fault <= 1'b0;
               end
            end
            default:
            begin
               state <= ST_IDLE;
               o_mem_read <= 1'b0;
            end
         endcase
      end
   end

endmodule // long_mode_page_walker
`default_nettype wire

/* tb/walker_mem_model.sv */
// table memory partner: every entry points at the next 4-Kbyte page, with junk in the ignored bits
// assumes the walker holds o_mem_read and o_mem_addr steady until it takes a valid pulse
`timescale 1ns/1ps
`default_nettype none
module walker_mem_model
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_mem_read,
   input wire logic [63:0] i_mem_addr,
   input wire logic i_big,
   input wire logic [3:0] i_lat,
   output logic o_valid,
   output logic [63:0] o_rdata
);
   logic [3:0] wait_cnt;
   logic [1:0] lvl;
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_valid <= 1'b0;
         wait_cnt <= 4'h0;
         lvl <= 2'h0;
         o_rdata <= 64'h0;
      end
      else
      begin
         o_valid <= 1'b0;
         // idle data toggles so a stale sample never looks like an entry
         o_rdata <= ~o_rdata;
         if (!i_mem_read)
            lvl <= 2'h0;
         else if (!o_valid && wait_cnt == i_lat)
         begin
            o_valid <= 1'b1;
            wait_cnt <= 4'h0;
            lvl <= lvl + 2'h1;
            // bit 7 set on pointer entries too, which must not make a 1-Gbyte page here
            o_rdata <= {12'hFFF, i_mem_addr[51:12] + 40'h1, 4'hF, lvl == 2'h1 || (i_big && lvl == 2'h2), 7'h63};
         end
         else if (!o_valid)
            wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule // walker_mem_model
`default_nettype wire

/* tb/long_mode_page_walker_asserts.sv */
// timing checks on the walker ports: fetch order, entry addresses, page stop, faults
// assumes the default VA_BITS of 48 and GBYTE_PAGES of 0
`timescale 1ns/1ps
`default_nettype none
`include "walker_defs.vh"
module long_mode_page_walker_asserts
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic i_req_valid,
   input wire logic [63:0] i_req_vaddr,
   input wire logic i_req_stack,
   input wire logic o_req_ready,
   input wire logic o_resp_valid,
   input wire logic [63:0] o_resp_paddr,
   input wire logic [1:0] o_resp_page_size,
   input wire logic o_resp_gp_fault,
   input wire logic o_resp_ss_fault,
   input wire logic o_mem_read,
   input wire logic [63:0] o_mem_addr,
   input wire logic o_mem_writethrough,
   input wire logic o_mem_uncached,
   input wire logic i_mem_valid,
   input wire logic [63:0] i_mem_rdata
);
   logic [2:0] lvl;
   logic [63:0] va;
   wire take = i_req_valid && o_req_ready;
   wire got = o_mem_read && i_mem_valid;
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lvl <= 3'h0;
         va <= 64'h0;
      end
      else if (take)
      begin
         lvl <= 3'h0;
         va <= i_req_vaddr;
      end
      else if (got)
         lvl <= lvl + 3'h1;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   sequence s_dir_got; got && lvl == 3'h2; endsequence
   sequence s_large; s_dir_got ##0 i_mem_rdata[7]; endsequence
   sequence s_small; s_dir_got ##0 !i_mem_rdata[7]; endsequence
   property p_wait_one; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("bus access waited more than one cycle");
   property p_idx;
      got |-> o_mem_addr[2:0] == 3'h0 && o_mem_addr[11:3] == (lvl == 3'h0 ? va[47:39] : lvl == 3'h1 ? va[38:30]
         : lvl == 3'h2 ? va[29:21] : va[20:12]);
   endproperty
   a_idx: assert property (p_idx) else $error("entry address index wrong");
   property p_phys; o_mem_read |-> o_mem_addr[63:52] == 12'h000; endproperty
   a_phys: assert property (p_phys) else $error("entry address beyond 52 bits");
   property p_next_base;
      got && (lvl < 3'h2 || (lvl == 3'h2 && !i_mem_rdata[7])) |=> o_mem_addr[51:12] == $past(i_mem_rdata[51:12]);
   endproperty
   a_next_base: assert property (p_next_base) else $error("next table base wrong");
   property p_large_stop;
      s_large |=> o_resp_valid && !o_mem_read && o_resp_page_size == `SIZE_2M
         && o_resp_paddr[51:21] == $past(i_mem_rdata[51:21]) && o_resp_paddr[20:0] == va[20:0];
   endproperty
   a_large_stop: assert property (p_large_stop) else $error("large page walk wrong");
   property p_small_go; s_small |=> o_mem_read; endproperty
   a_small_go: assert property (p_small_go) else $error("walk stopped at directory");
   property p_4k_done;
      got && lvl == 3'h3 |=> o_resp_valid && o_resp_page_size == `SIZE_4K
         && o_resp_paddr[51:12] == $past(i_mem_rdata[51:12]) && o_resp_paddr[11:0] == va[11:0];
   endproperty
   a_4k_done: assert property (p_4k_done) else $error("small page result wrong");
   property p_noncanon;
      take && i_req_vaddr[63:47] != 17'h00000 && i_req_vaddr[63:47] != 17'h1FFFF
         |=> o_resp_valid && ($past(i_req_stack) ? o_resp_ss_fault : o_resp_gp_fault);
   endproperty
   a_noncanon: assert property (p_noncanon) else $error("non-canonical address not faulted");
   property p_l4_attr; o_mem_writethrough || o_mem_uncached |-> o_mem_read && lvl == 3'h0; endproperty
   a_l4_attr: assert property (p_l4_attr) else $error("table attributes outside top fetch");
endmodule // long_mode_page_walker_asserts
bind long_mode_page_walker long_mode_page_walker_asserts chk_u (.i_ref_clk, .i_rst, .i_avs_read, .i_avs_write,
   .o_avs_waitrequest, .i_req_valid, .i_req_vaddr, .i_req_stack, .o_req_ready, .o_resp_valid, .o_resp_paddr,
   .o_resp_page_size, .o_resp_gp_fault, .o_resp_ss_fault, .o_mem_read, .o_mem_addr, .o_mem_writethrough,
   .o_mem_uncached, .i_mem_valid, .i_mem_rdata);
`default_nettype wire

/* tb/long_mode_page_walker_tb.sv */
// bench for the page walker: register setup, a table of walks and faults, status and reset checks
// assumes the memory model answers each entry with the next page, after a chosen latency
`timescale 1ns/1ps
`default_nettype none
`include "walker_defs.vh"
module long_mode_page_walker_tb;
   localparam logic [63:0] PGM = 64'h000F_FFFF_FFFF_F000;
   typedef struct { logic [63:0] va; logic [2:0] last; logic stk; logic big; logic [1:0] flt; } row_t;
   row_t rows[6] = '{'{64'h0000_1234_5678_9ABC, 3'h3, 1'b0, 1'b0, 2'h0},
      '{64'hFFFF_8000_0000_0FFF, 3'h0, 1'b1, 1'b0, 2'h0}, '{64'h0000_7FFF_FFE0_1234, 3'h7, 1'b0, 1'b1, 2'h0},
      '{64'h0000_8000_0000_0000, 3'h0, 1'b0, 1'b0, 2'h1}, '{64'hFFFF_7FFF_FFFF_FFF0, 3'h0, 1'b1, 1'b0, 2'h2},
      '{64'h0000_7FFF_FFFF_FFFC, 3'h7, 1'b0, 1'b0, 2'h1}};
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0, wr = 1'b0, req = 1'b0, stk = 1'b0, big = 1'b0, attr;
   logic [31:0] wdat = 32'h0, rdat, d;
   logic [63:0] vaddr = 64'h0, paddr, maddr, mdata, pa, b, ex;
   logic [2:0] last = 3'h0;
   logic [3:0] lat = 4'h0;
   logic [1:0] psize;
   logic waitreq, ready, resp_v, gp, ss, mrd, mv, wt, uc;
   logic [63:0] q[$];
   logic [63:0] ea[4];
   int n_fail = 0, num_checks = 0, cyc = 0, nlv;
   always #10 i_ref_clk = ~i_ref_clk;
   long_mode_page_walker dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
      .o_avs_waitrequest(waitreq), .i_req_valid(req), .i_req_vaddr(vaddr), .i_req_last_byte(last),
      .i_req_stack(stk), .o_req_ready(ready), .o_resp_valid(resp_v), .o_resp_paddr(paddr),
      .o_resp_page_size(psize), .o_resp_gp_fault(gp), .o_resp_ss_fault(ss), .o_mem_read(mrd), .o_mem_addr(maddr),
      .o_mem_writethrough(wt), .o_mem_uncached(uc), .i_mem_valid(mv), .i_mem_rdata(mdata));
   walker_mem_model mem_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mem_read(mrd), .i_mem_addr(maddr),
      .i_big(big), .i_lat(lat), .o_valid(mv), .o_rdata(mdata));
   task automatic wrap_up();
      $display("checks=%0d failures=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
      @(posedge i_ref_clk);
      adr <= a;
      wdat <= v;
      rd <= !w;
      wr <= w;
      do @(posedge i_ref_clk); while (waitreq !== 1'b0);
      d = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic xl(input row_t r, input logic [3:0] l);
      q.delete();
      attr = 1'b0;
      @(posedge i_ref_clk);
      vaddr <= r.va;
      last <= r.last;
      stk <= r.stk;
      big <= r.big;
      lat <= l;
      req <= 1'b1;
      do @(posedge i_ref_clk); while (ready !== 1'b1);
      req <= 1'b0;
      do @(posedge i_ref_clk); while (resp_v !== 1'b1);
      pa = paddr;
   endtask
   always @(negedge i_ref_clk)
   begin
      if (mrd && mv)
         q.push_back(maddr);
      if (wt && uc)
         attr = 1'b1;
   end
   always @(posedge i_ref_clk)
   begin
      cyc <= cyc + 1;
      // a walk should never take more than a few dozen cycles
      if (cyc == 20000)
      begin
         n_fail++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (16) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      // reserved fields and bits above the implemented base written as zero
      bus(1'b1, `OFS_ROOT_LO, 32'h0000_5018);
      bus(1'b1, `OFS_ROOT_HI, 32'h0000_0003);
      bus(1'b1, `OFS_CONTROL, 32'h0000_0004);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(d & 32'h7, 32'h4);
      xl(rows[0], 4'h0);
      chk({gp, ss}, 2'b10);
      // legacy large-page enable set as well, it must change nothing
      bus(1'b1, `OFS_CONTROL, 32'h0000_0007);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(d & 32'h1, 32'h1);
      for (int i = 0; i < 6; i++)
      begin
         xl(rows[i], 4'(3 * i));
         if (rows[i].flt == 2'h0)
         begin
            b = 64'h0000_0003_0000_5000;
            nlv = rows[i].big ? 3 : 4;
            for (int k = 0; k < nlv; k++)
            begin
               ea[k] = b | {52'h0, rows[i].va[47 - 9 * k -: 9], 3'h0};
               b = ((ea[k] & PGM) + 64'h1000) & PGM;
            end
            ex = rows[i].big ? (b & 64'h000F_FFFF_FFE0_0000) | rows[i].va[20:0] : b | rows[i].va[11:0];
            chk(64'(q.size()), 64'(nlv));
            for (int k = 0; k < nlv; k++) chk(q[k], ea[k]);
            chk(pa, ex);
            chk(psize, rows[i].big ? `SIZE_2M : `SIZE_4K);
            chk(attr, 1'b1);
         end
         else
         begin
            chk({gp, ss}, rows[i].flt == 2'h1 ? 2'b10 : 2'b01);
            chk(64'(q.size()), 64'h0);
         end
      end
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(d & 32'h1D, 32'h1D);
      // the last byte, not the first, was the offending one
      bus(1'b0, `OFS_FAULT_VA_LO, 32'h0);
      chk(d, 32'h0000_0003);
      bus(1'b0, `OFS_FAULT_VA_HI, 32'h0);
      chk(d, 32'h0000_8000);
      bus(1'b1, `OFS_STATUS, 32'h0000_001C);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(d & 32'h1D, 32'h1);
      bus(1'b0, 5'h02, 32'h0);
      chk(d, 32'h0);
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      bus(1'b0, `OFS_CONTROL, 32'h0);
      chk(d, 32'h0);
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk(d, 32'h0);
      wrap_up();
   end
endmodule // long_mode_page_walker_tb
`default_nettype wire
